/* File: hw/scl_pkg.sv */
// strap capture and reset timing: shared constants
// assumes a 100 MHz pclk and 32-bit apb data
package scl_pkg;
   // strap vector layout, index equals the strap pin index
   localparam int          STRAP_W        = 13;
   localparam int          ADDR_LSB       = 0;
   localparam int          ADDR_W         = 3;
   localparam int          DUPLEX_BIT     = 3;
   localparam int          IFSEL_LSB      = 4;
   localparam int          IFSEL_W        = 3;
   localparam int          ISO_BIT        = 7;
   localparam int          TESTN_BIT      = 8;
   localparam int          ANEG_BIT       = 9;
   localparam int          SPEED_BIT      = 10;
   localparam int          PWRDN_BIT      = 11;
   localparam int          RSV_BIT        = 12;
   localparam int          MII_PINS       = 8;
   // weak-resistor defaults: 0 pull-down, 1 pull-up
   localparam logic [12:0] STRAP_DEFAULT  = 13'h1708;
   localparam logic [1:0]  ADDR_UPPER     = 2'h1;
   localparam logic [2:0]  IFSEL_MII      = 3'h0;
   localparam logic [2:0]  IFSEL_RMII     = 3'h1;

   // register byte offsets
   localparam logic [7:0]  REG_STRAP      = 8'h00;
   localparam logic [7:0]  REG_OVR        = 8'h04;
   localparam logic [7:0]  REG_DBG_TEST   = 8'h08;
   localparam logic [7:0]  REG_DBG_PSAVE  = 8'h0C;
   localparam logic [7:0]  REG_STAT       = 8'h10;
   localparam int          STRAP_DONE_BIT = 16;
   localparam int          OVR_EN_BIT     = 31;
   localparam int          DBG_FIX_BIT    = 3;
   localparam logic        DBG_FIX_RST    = 1'h1;
   localparam logic [2:0]  PSAVE_RST      = 3'h0;
   localparam logic [2:0]  PSAVE_FIX      = 3'h4;
   localparam int          ST_INRST       = 0;
   localparam int          ST_RSVCODE     = 1;
   localparam int          ST_SHORT       = 2;
   localparam int          ST_FIXED       = 3;

   // warm reset minimum
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          WARM_MIN_MS    = 1;
   localparam int          WARM_MIN_CYC   = WARM_MIN_MS * 1000000
                                            / CLK_PERIOD_NS;
   localparam int          LOWCNT_W       = 20;

   // late-clock register fix-up progress
   typedef enum logic [2:0] {
      FIX_IDLE = 3'b001,
      FIX_CLR  = 3'b010,
      FIX_DONE = 3'b100
   } scl_fix_e;
endpackage : scl_pkg

/* File: hw/scl_strap_latch.sv */
// strap latch: samples the strap pins as hardware reset is released
// assumes hw_rst_n is synchronous to pclk
module scl_strap_latch
   import scl_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               hw_rst_n,
   input  wire logic [STRAP_W-1:0] pin_i,
   output logic      [STRAP_W-1:0] capt_q,
   output logic                    done_q,
   output logic                    rst_seen_q
);
   logic rst_prev_q;
   wire  rise = !rst_prev_q && hw_rst_n;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_prev_q <= 1'b0;
         capt_q     <= STRAP_DEFAULT;
         done_q     <= 1'b0;
         rst_seen_q <= 1'b0;
      end else begin
         rst_prev_q <= hw_rst_n;
         if (!hw_rst_n) begin
            capt_q <= STRAP_DEFAULT;
            done_q <= 1'b0;
         end else if (rise) begin
            capt_q     <= pin_i;
            done_q     <= 1'b1;
            rst_seen_q <= 1'b1;
         end
      end
   end
endmodule : scl_strap_latch

/* File: hw/scl_top.sv */
// strap capture, reset hold and late-clock fix-up registers on apb
// assumes synchronous pins, board pulls on strap pins, apb master
//
// Contract
// - low three management address bits come from three strapped rx pins
// - upper management address bits are a fixed constant
// - duplex strap: 0 half, 1 full, default full
// - interface strap 000 mii, 001 rmii, others reserved, default 000
// - interrupt pin strap: 0 test mode, 1 normal, default normal
// - rx clock strap: 0 power-down off, 1 on, default off
// - weak pulls set defaults; tx clock strap reserved, default 1
//
// The placing of the registers and the APB register port were left to the implementer.
module scl_top
   import scl_pkg::*;
#(
   parameter int WARM_MIN = WARM_MIN_CYC
)(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               hw_rst_n,
   input  wire logic [STRAP_W-1:0] strap_pin_i,
   output logic      [STRAP_W-1:0] strap_pin_o,
   output logic      [STRAP_W-1:0] strap_pin_oe,
   input  wire logic [STRAP_W-1:0] func_o,
   output logic      [4:0]         mgmt_addr_strap,
   output logic                    duplex_full,
   output logic                    rmii_sel,
   output logic                    isolate,
   output logic                    test_mode_n,
   output logic                    autoneg_en,
   output logic                    speed_100,
   output logic                    power_down,
   output logic                    core_run,
   output logic                    dbg_test_bit,
   output logic      [2:0]         dbg_psave
);
   logic [STRAP_W-1:0] capt;
   logic               done;
   logic               rst_seen;
   logic [STRAP_W-1:0] ovr_q;
   logic               ovr_en_q;
   logic [STRAP_W-1:0] cfg_q;
   logic               dbg_fix_q;
   logic [2:0]         psave_q;
   logic               short_q;
   logic [LOWCNT_W-1:0] low_cnt_q;
   logic [31:0]        rdata_q;
   logic [STRAP_W-1:0] pin_o_q;
   logic [STRAP_W-1:0] pin_oe_q;
   scl_fix_e           fix_q;
   scl_fix_e           fix_d;

   scl_strap_latch u_latch (
      .pclk       (pclk),
      .presetn    (presetn),
      .hw_rst_n   (hw_rst_n),
      .pin_i      (strap_pin_i),
      .capt_q     (capt),
      .done_q     (done),
      .rst_seen_q (rst_seen)
   );

   // apb decode
   wire hit_strap = (paddr == REG_STRAP);
   wire hit_ovr   = (paddr == REG_OVR);
   wire hit_test  = (paddr == REG_DBG_TEST);
   wire hit_psave = (paddr == REG_DBG_PSAVE);
   wire hit_stat  = (paddr == REG_STAT);
   wire mapped    = hit_strap | hit_ovr | hit_test | hit_psave | hit_stat;
   wire access    = psel & penable;
   wire wr        = access & pwrite & mapped;
   wire setup_rd  = psel & !penable & !pwrite;
   wire wr_ovr    = wr & hit_ovr;
   wire wr_test   = wr & hit_test & done;
   wire wr_psave  = wr & hit_psave & done;
   wire wr_stat   = wr & hit_stat;

   assign pready  = access;
   assign pslverr = access & !mapped;
   assign prdata  = rdata_q;

   // effective configuration: override or captured straps
   wire [STRAP_W-1:0] eff     = ovr_en_q ? ovr_q : capt;
   wire [2:0]         ifsel   = eff[IFSEL_LSB +: IFSEL_W];
   wire               rsvcode = (ifsel != IFSEL_MII) && (ifsel != IFSEL_RMII);
   wire               warm_rise = !done && hw_rst_n && rst_seen;
   wire               short_set =
      warm_rise && (low_cnt_q < LOWCNT_W'(WARM_MIN));

   wire [31:0] stat_word = {28'h0000000, (fix_q == FIX_DONE), short_q,
                            rsvcode, !done};
   wire [31:0] rd_mux =
      hit_strap ? {15'h0000, done, 3'h0, capt} :
      hit_ovr   ? {ovr_en_q, 18'h00000, ovr_q} :
      hit_test  ? {28'h0000000, dbg_fix_q, 3'h0} :
      hit_psave ? {29'h00000000, psave_q} :
      hit_stat  ? stat_word : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h00000000;
      end else if (setup_rd) begin
         rdata_q <= rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovr_q    <= STRAP_DEFAULT;
         ovr_en_q <= 1'b0;
      end else if (wr_ovr) begin
         ovr_q    <= pwdata[STRAP_W-1:0];
         ovr_en_q <= pwdata[OVR_EN_BIT];
      end
   end

   // debug registers, held at reset values while in hardware reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbg_fix_q <= DBG_FIX_RST;
         psave_q   <= PSAVE_RST;
      end else if (!done) begin
         dbg_fix_q <= DBG_FIX_RST;
         psave_q   <= PSAVE_RST;
      end else begin
         if (wr_test) dbg_fix_q <= pwdata[DBG_FIX_BIT];
         if (wr_psave) psave_q <= pwdata[2:0];
      end
   end

   // fix-up order tracking
   always_comb begin
      fix_d = fix_q;
      case (fix_q)
         FIX_IDLE: begin
            if (wr_test && !pwdata[DBG_FIX_BIT]) fix_d = FIX_CLR;
         end
         FIX_CLR: begin
            if (wr_test && pwdata[DBG_FIX_BIT]) fix_d = FIX_IDLE;
            else if (wr_psave && pwdata[2:0] == PSAVE_FIX) begin
               fix_d = FIX_DONE;
            end
         end
         FIX_DONE: begin
            if (wr_test && pwdata[DBG_FIX_BIT]) fix_d = FIX_IDLE;
         end
         default: fix_d = FIX_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fix_q <= FIX_IDLE;
      end else if (!done) begin
         fix_q <= FIX_IDLE;
      end else begin
         fix_q <= fix_d;
      end
   end

   // warm reset length monitor, sticky flag, write one to clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt_q <= '0;
         short_q   <= 1'b0;
      end else begin
         if (hw_rst_n) low_cnt_q <= '0;
         else if (low_cnt_q < LOWCNT_W'(WARM_MIN)) begin
            low_cnt_q <= low_cnt_q + 1'b1;
         end
         if (short_set) short_q <= 1'b1;
         else if (wr_stat && pwdata[ST_SHORT]) short_q <= 1'b0;
      end
   end

   // configuration outputs, defaults while in reset unless the override is enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= STRAP_DEFAULT;
      end else begin
         cfg_q <= eff;
      end
   end

   assign mgmt_addr_strap = {ADDR_UPPER, cfg_q[ADDR_LSB +: ADDR_W]};
   assign duplex_full = cfg_q[DUPLEX_BIT];
   assign rmii_sel    = cfg_q[IFSEL_LSB +: IFSEL_W] == IFSEL_RMII;
   assign isolate     = cfg_q[ISO_BIT];
   assign test_mode_n = cfg_q[TESTN_BIT];
   assign autoneg_en  = cfg_q[ANEG_BIT];
   assign speed_100   = cfg_q[SPEED_BIT];
   assign power_down  = cfg_q[PWRDN_BIT];
   assign core_run    = done;
   assign dbg_test_bit = dbg_fix_q;
   assign dbg_psave   = psave_q;

   // pins float for the pulls until straps are latched
   genvar gi;
   generate
      for (gi = 0; gi < STRAP_W; gi++) begin : g_pin
         wire quiet = (gi < MII_PINS) && cfg_q[ISO_BIT];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_o_q[gi]  <= 1'b0;
               pin_oe_q[gi] <= 1'b0;
            end else begin
               pin_o_q[gi]  <= func_o[gi];
               pin_oe_q[gi] <= done && hw_rst_n && !quiet;
            end
         end
      end
   endgenerate

   assign strap_pin_o  = pin_o_q;
   assign strap_pin_oe = pin_oe_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_addr_low;
      $rose(done) && !ovr_en_q |=>
         mgmt_addr_strap[2:0] == $past(strap_pin_i[2:0], 2);
   endproperty
   a_addr_low: assert property (p_addr_low)
      else $error("address low bits not from straps");

   property p_addr_up;
      core_run |-> mgmt_addr_strap[4:3] == 2'h1;
   endproperty
   a_addr_up: assert property (p_addr_up)
      else $error("address upper bits wrong");

   property p_duplex;
      $rose(done) && !ovr_en_q |=> duplex_full == $past(strap_pin_i[3], 2);
   endproperty
   a_duplex: assert property (p_duplex)
      else $error("duplex not from strap");

   property p_ifsel;
      $rose(done) && !ovr_en_q |=>
         rmii_sel == ($past(strap_pin_i[6:4], 2) == 3'h1);
   endproperty
   a_ifsel: assert property (p_ifsel)
      else $error("interface select not from strap");

   property p_iso;
      done && isolate |=> strap_pin_oe[7:0] == 8'h00;
   endproperty
   a_iso: assert property (p_iso)
      else $error("mii pins driven while isolated");

   property p_misc;
      $rose(done) && !ovr_en_q |=>
         {power_down, speed_100, autoneg_en, test_mode_n}
            == $past(strap_pin_i[11:8], 2);
   endproperty
   a_misc: assert property (p_misc)
      else $error("mode straps not latched");

   property p_default;
      !done && !ovr_en_q ##1 !done |->
         {duplex_full, test_mode_n, autoneg_en, speed_100} == 4'hF
         && !power_down && !isolate;
   endproperty
   a_default: assert property (p_default)
      else $error("defaults not shown during reset");

   property p_release;
      $rose(done) |-> strap_pin_oe[12] == 1'b0 ##1 strap_pin_oe[12];
   endproperty
   a_release: assert property (p_release)
      else $error("pins not released after strap latch");

   property p_hold;
      !hw_rst_n |=> !core_run && strap_pin_oe == 13'h0000
         ##1 fix_q == FIX_IDLE;
   endproperty
   a_hold: assert property (p_hold)
      else $error("logic running during hardware reset");

   property p_fix;
      fix_q == FIX_IDLE && wr_psave |=> fix_q != FIX_DONE;
   endproperty
   a_fix: assert property (p_fix)
      else $error("fix-up accepted out of order");
endmodule : scl_top

/* File: tb/scl_board.sv */
// board strap resistors plus the weak pulls on the strap pins
// assumes oe high means the device drives the pin
module scl_board
   import scl_pkg::*;
(
   input  wire logic [STRAP_W-1:0] pin_o,
   input  wire logic [STRAP_W-1:0] pin_oe,
   input  wire logic [STRAP_W-1:0] fit,
   input  wire logic [STRAP_W-1:0] val,
   output logic      [STRAP_W-1:0] pin_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // driven pin wins, then a fitted resistor, then the weak pull
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & fit & val)
                | (~pin_oe & ~fit & STRAP_DEFAULT);
endmodule : scl_board

/* File: tb/tb.sv */
// self-checking bench for strap capture, reset hold and fix-up
// assumes scl_board models the pins and the bench is the reset controller
module tb
   import scl_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WM = 20;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        hw_rst_n, duplex_full, rmii_sel, isolate, test_mode_n;
   logic        autoneg_en, speed_100, power_down, core_run, dbg_test_bit;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [12:0] pin_i, pin_o, pin_oe, func_o, bfit, bval;
   logic [4:0]  mgmt_addr_strap;
   logic [2:0]  dbg_psave;
   logic        er;
   int          errors, checked, cyc;

   scl_top #(.WARM_MIN(WM)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hw_rst_n(hw_rst_n),
      .strap_pin_i(pin_i), .strap_pin_o(pin_o), .strap_pin_oe(pin_oe),
      .func_o(func_o), .mgmt_addr_strap(mgmt_addr_strap),
      .duplex_full(duplex_full), .rmii_sel(rmii_sel), .isolate(isolate),
      .test_mode_n(test_mode_n), .autoneg_en(autoneg_en),
      .speed_100(speed_100), .power_down(power_down),
      .core_run(core_run), .dbg_test_bit(dbg_test_bit),
      .dbg_psave(dbg_psave));
   scl_board board (.pin_o(pin_o), .pin_oe(pin_oe), .fit(bfit),
      .val(bval), .pin_i(pin_i));

   always #5 pclk = ~pclk;

   task automatic close_out;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         close_out();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (e !== g) begin
         errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   // one apb transfer; waits for pready, takes data at that edge
   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // hardware reset pulse with given board straps
   task automatic hw_pulse(input logic [12:0] v, input logic [12:0] f,
                           input int len);
      @(posedge pclk);
      bval <= v;
      bfit <= f;
      hw_rst_n <= 1'b0;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("run_in_rst", 0, {31'h0, core_run});
      chk("oe_in_rst", 0, {19'h0, pin_oe});
      repeat (len - 2) @(posedge pclk);
      hw_rst_n <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask : hw_pulse

   task automatic cfg_chk(input logic [12:0] s);
      @(negedge pclk);
      chk("cfg", {20'h0, ADDR_UPPER, s[2:0], s[3], s[6:4] === IFSEL_RMII,
          s[7], s[8], s[9], s[10], s[11]}, {20'h0, mgmt_addr_strap,
          duplex_full, rmii_sel, isolate, test_mode_n, autoneg_en,
          speed_100, power_down});
      chk("oe", s[7] ? 32'h1F00 : 32'h1FFF, {19'h0, pin_oe});
      chk("pin_o", {19'h0, func_o}, {19'h0, pin_o});
      apb(REG_STRAP, 1'b0, 0);
      chk("strap_reg", 32'h10000 | {19'h0, s}, rd);
   endtask : cfg_chk

   task automatic t_defaults;
      hw_pulse(13'h0, 13'h0, WM + 10);
      cfg_chk(STRAP_DEFAULT);
   endtask : t_defaults

   task automatic t_pattern;
      hw_pulse(13'h1895, 13'h1FFF, WM + 10);
      cfg_chk(13'h1895);
   endtask : t_pattern

   task automatic t_ifsel;
      logic [12:0] v;
      for (int c = 0; c < 8; c++) begin
         v = STRAP_DEFAULT;
         v[6:4] = c[2:0];
         hw_pulse(v, 13'h1FFF, WM + 10);
         apb(REG_STAT, 1'b0, 0);
         chk("ifsel", {30'h0, c > 1, c == 1}, {30'h0, rd[1], rmii_sel});
      end
   endtask : t_ifsel

   task automatic t_fix;
      hw_pulse(13'h0, 13'h0, WM + 10);
      chk("dbg_rst", {28'h0, DBG_FIX_RST, PSAVE_RST},
          {28'h0, dbg_test_bit, dbg_psave});
      apb(REG_DBG_PSAVE, 1'b1, 32'h4);
      apb(REG_STAT, 1'b0, 0);
      chk("fix_early", 0, {31'h0, rd[ST_FIXED]});
      apb(REG_DBG_TEST, 1'b1, 32'h0);
      apb(REG_DBG_PSAVE, 1'b1, 32'h4);
      apb(REG_STAT, 1'b0, 0);
      chk("fix_done", 1, {31'h0, rd[ST_FIXED]});
      chk("dbg_fix", {28'h0, 1'b0, PSAVE_FIX},
          {28'h0, dbg_test_bit, dbg_psave});
   endtask : t_fix

   task automatic t_short;
      apb(REG_STAT, 1'b1, 32'h4);
      hw_pulse(13'h0, 13'h0, 10);
      apb(REG_STAT, 1'b0, 0);
      chk("short", 1, {31'h0, rd[ST_SHORT]});
      apb(REG_STAT, 1'b1, 32'h4);
      hw_pulse(13'h0, 13'h0, WM + 10);
      apb(REG_STAT, 1'b0, 0);
      chk("long", 0, {31'h0, rd[ST_SHORT]});
   endtask : t_short

   task automatic t_bus;
      apb(8'h14, 1'b0, 0);
      chk("unmapped", 32'h1, {rd[30:0], er});
      apb(REG_OVR, 1'b0, 0);
      chk("ovr_rst", 32'h1708, rd);
      apb(REG_OVR, 1'b1, 32'h80000E08);
      repeat (2) @(negedge pclk);
      chk("ovr_cfg", 32'h45, {24'h0, mgmt_addr_strap, power_down,
          test_mode_n, duplex_full});
      apb(REG_OVR, 1'b0, 0);
      chk("ovr_rd", 32'h80000E08, rd);
   endtask : t_bus

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      hw_rst_n = 1'b0;
      func_o = 13'h0A5A;
      bfit = 13'h0;
      bval = 13'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_defaults();
      t_pattern();
      t_ifsel();
      t_fix();
      t_short();
      t_bus();
      close_out();
   end
endmodule : tb
